// ---- charger_control_regs.v ----
// What this block does
// - restore bit resets all registers, self-clears
// - thermal select: zero 60C, one 120C
// - switch rate trim codes, code 3 reserved
// - gate drive weak/normal/strong, default strong
// - overvoltage level 6.3V or 18.5V, default high
// - boost on bit, cleared by restore, watchdog
// - boost pulse skip disable bit
// - buck pulse skip disable bit
// - pass switch with input bit read-only zero
// - action delay 20ms or 10s, default 10s
// - action codes normal/shutdown/ship/system reset
// - discharge peak limit codes, default 12A
// - undervoltage and short thresholds chosen together
// - boost minimum cell level selection
// - clearing nine after success: twelve or release
// - both requested: twelve first, nine only if twelve fails
// - clearing twelve with nine set starts nine
// - variant b: bit 2 external limit enable
// - fast stage rate sets foldback divisor
//
// holds the three charger control registers behind a byte-wide register port
// fed by the serial management engine; analogue loops consume the outputs
`timescale 1ns/1ps
`include "charger_control_defines.vh"

module charger_control_regs #(
  parameter VARIANT_B = 0,
  parameter SHORT_DLY_CYC = `PSW_SHORT_DLY_CYC,
  parameter LONG_DLY_CYC = `PSW_LONG_DLY_CYC
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire wdog_expire_i,
  input wire adapter_present_i,
  input wire det_done_i,
  input wire det_ok_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  output reg timer_reset_o,
  output reg thermal_limit_select_o,
  output reg [1:0] switch_rate_trim_o,
  output reg [1:0] gate_drive_level_o,
  output reg input_overvoltage_level_o,
  output reg boost_output_on_o,
  output reg boost_pulse_skip_off_o,
  output reg buck_pulse_skip_off_o,
  output reg [1:0] psw_fire_code_o,
  output reg psw_fire_o,
  output reg [1:0] discharge_peak_limit_o,
  output reg cell_undervoltage_level_o,
  output reg boost_min_cell_level_o,
  output reg external_limit_pin_on_o,
  output reg [2:0] fast_stage_divisor_o,
  output reg det_start_o,
  output reg det_target_12v_o,
  output reg bias_release_o,
  output reg [1:0] adapter_level_o
);

  // ----------------------------------------------------------------------------
  // stored fields
  // ----------------------------------------------------------------------------
  localparam [7:0] PROT_RST = VARIANT_B ? `RST_PROT_CTL4_VARB : `RST_PROT_CTL4;
  // named copies, since a bare literal cannot be sliced
  localparam [7:0] CTL2_RST = `RST_CONV_CTL2;
  localparam [7:0] CTL3_RST = `RST_PSW_CTL3;

  reg thermal_r; // thermal limit select
  reg [1:0] freq_r; // switch rate trim, as written
  reg [1:0] strn_r; // gate drive level, as written
  reg ovp_r; // input overvoltage level
  reg boost_on_r; // boost output on
  reg boost_pfm_r; // boost pulse skip off
  reg buck_pfm_r; // buck pulse skip off
  reg psw_dly_r; // long action delay
  reg [1:0] psw_act_r; // pass switch action
  reg [1:0] peak_r; // discharge peak limit
  reg uvlo_r; // cell undervoltage pair
  reg otg_min_r; // boost minimum cell level
  reg req9_r; // nine volt request
  reg req12_r; // twelve volt request or external limit enable
  reg [1:0] rate_r; // fast stage c rate

  // ----------------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------------
  wire wr_ctl2 = reg_wr_i && (reg_addr_i == `ADDR_CONV_CTL2);
  wire wr_ctl3 = reg_wr_i && (reg_addr_i == `ADDR_PSW_CTL3);
  wire wr_ctl4 = reg_wr_i && (reg_addr_i == `ADDR_PROT_CTL4);
  // restore wins over every other write in the same cycle
  wire restore = wr_ctl2 && reg_wdata_i[`BIT_RESTORE];

  wire seq_fire; // sequencer fired its action
  wire [1:0] seq_code; // action it fired
  wire hv_start; // negotiator outputs
  wire hv_tgt12;
  wire hv_release;
  wire [1:0] hv_level;

  // ----------------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------------
  // restore and async reset load the same defaults
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {thermal_r, freq_r, strn_r, ovp_r} <= {CTL2_RST[6:2], CTL2_RST[0]};
      {boost_on_r, boost_pfm_r, buck_pfm_r} <= CTL3_RST[6:4];
      {psw_dly_r, psw_act_r} <= CTL3_RST[2:0];
      {peak_r, uvlo_r, otg_min_r, req9_r, req12_r, rate_r} <= PROT_RST;
    end else if (restore) begin
      {thermal_r, freq_r, strn_r, ovp_r} <= {CTL2_RST[6:2], CTL2_RST[0]};
      {boost_on_r, boost_pfm_r, buck_pfm_r} <= CTL3_RST[6:4];
      {psw_dly_r, psw_act_r} <= CTL3_RST[2:0];
      {peak_r, uvlo_r, otg_min_r, req9_r, req12_r, rate_r} <= PROT_RST;
    end else begin
      if (wr_ctl2) begin
        thermal_r <= reg_wdata_i[`BIT_THERMAL];
        freq_r <= reg_wdata_i[5:4];
        strn_r <= reg_wdata_i[3:2];
        ovp_r <= reg_wdata_i[`BIT_OVP];
      end
      // watchdog clears boost; a host write in the same cycle still lands
      if (wr_ctl3) begin
        boost_on_r <= reg_wdata_i[`BIT_BOOST_ON];
        boost_pfm_r <= reg_wdata_i[`BIT_BOOST_PFM];
        buck_pfm_r <= reg_wdata_i[`BIT_BUCK_PFM];
        psw_dly_r <= reg_wdata_i[`BIT_PSW_DLY];
        psw_act_r <= reg_wdata_i[1:0];
      end else begin
        if (wdog_expire_i) begin
          boost_on_r <= 1'b0;
        end
        if (seq_fire) begin
          psw_act_r <= `ACT_NORMAL; // one-shot action
        end
      end
      if (wr_ctl4) begin
        peak_r <= reg_wdata_i[7:6];
        uvlo_r <= reg_wdata_i[`BIT_UVLO];
        otg_min_r <= reg_wdata_i[`BIT_OTG_MIN];
        // nine volt bit is reserved on variant b
        req9_r <= VARIANT_B ? 1'b0 : reg_wdata_i[`BIT_REQ9];
        req12_r <= reg_wdata_i[`BIT_REQ12];
        rate_r <= reg_wdata_i[1:0];
      end else if (wdog_expire_i) begin
        req12_r <= PROT_RST[`BIT_REQ12];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------------------
  reg [7:0] rd_mux; // value of the addressed register

  // restore bit always reads zero; reserved bits read their reset value
  always @* begin
    if (reg_addr_i == `ADDR_CONV_CTL2) begin
      rd_mux = {1'b0, thermal_r, freq_r, strn_r, CTL2_RST[`BIT_RSVD_CTL2], ovp_r};
    end else if (reg_addr_i == `ADDR_PSW_CTL3) begin
      // bit 7 reserved, bit 3 read-only zero
      rd_mux = {1'b0, boost_on_r, boost_pfm_r, buck_pfm_r, 1'b0, psw_dly_r, psw_act_r};
    end else if (reg_addr_i == `ADDR_PROT_CTL4) begin
      rd_mux = {peak_r, uvlo_r, otg_min_r, req9_r, req12_r, rate_r};
    end else begin
      rd_mux = 8'h00; // unmapped
    end
  end

  // read data registered, valid one cycle after the strobe
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // effective settings
  // ----------------------------------------------------------------------------
  // reserved codes leave the last legal setting in force; that keeps a bad
  // write from pushing the converter into an untested corner
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_reset_o <= 1'b0;
      thermal_limit_select_o <= CTL2_RST[`BIT_THERMAL];
      switch_rate_trim_o <= CTL2_RST[5:4];
      gate_drive_level_o <= CTL2_RST[3:2];
      input_overvoltage_level_o <= CTL2_RST[`BIT_OVP];
      boost_output_on_o <= 1'b0;
      boost_pulse_skip_off_o <= 1'b0;
      buck_pulse_skip_off_o <= 1'b0;
      discharge_peak_limit_o <= PROT_RST[7:6];
      cell_undervoltage_level_o <= 1'b0;
      boost_min_cell_level_o <= 1'b0;
      external_limit_pin_on_o <= 1'b0;
      fast_stage_divisor_o <= 3'h1;
    end else begin
      timer_reset_o <= restore;
      thermal_limit_select_o <= thermal_r;
      if (freq_r != `FREQ_RESERVED) begin
        switch_rate_trim_o <= freq_r;
      end
      if (strn_r != `STRN_RESERVED) begin
        gate_drive_level_o <= strn_r;
      end
      input_overvoltage_level_o <= ovp_r;
      boost_output_on_o <= boost_on_r;
      boost_pulse_skip_off_o <= boost_pfm_r;
      buck_pulse_skip_off_o <= buck_pfm_r;
      discharge_peak_limit_o <= peak_r;
      cell_undervoltage_level_o <= uvlo_r;
      boost_min_cell_level_o <= otg_min_r;
      external_limit_pin_on_o <= VARIANT_B ? req12_r : 1'b0;
      // divisor for foldback = charge setting x ratio / rate
      case (rate_r)
        2'h0: fast_stage_divisor_o <= 3'h1;
        2'h1: fast_stage_divisor_o <= 3'h2;
        2'h2: fast_stage_divisor_o <= 3'h4;
        default: fast_stage_divisor_o <= 3'h6;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // pass switch action and adapter negotiation
  // ----------------------------------------------------------------------------
  pass_switch_sequencer #(
    .SHORT_DLY_CYC(SHORT_DLY_CYC),
    .LONG_DLY_CYC(LONG_DLY_CYC)
  ) u_psw (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .action_i(psw_act_r),
    .long_dly_i(psw_dly_r),
    .adapter_present_i(adapter_present_i),
    .fire_code_o(seq_code),
    .fire_o(seq_fire)
  );

  // negotiation exists only on the first variant
  hv_negotiator u_hv (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(VARIANT_B == 0),
    .nine_volt_request_i(req9_r),
    .twelve_volt_request_i(req12_r),
    .det_done_i(det_done_i),
    .det_ok_i(det_ok_i),
    .det_start_o(hv_start),
    .det_target_12v_o(hv_tgt12),
    .bias_release_o(hv_release),
    .adapter_level_o(hv_level)
  );

  // outputs re-registered so every top output leaves a flip-flop here
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      psw_fire_o <= 1'b0;
      psw_fire_code_o <= 2'h0;
      det_start_o <= 1'b0;
      det_target_12v_o <= 1'b0;
      bias_release_o <= 1'b0;
      adapter_level_o <= 2'h0;
    end else begin
      psw_fire_o <= seq_fire;
      psw_fire_code_o <= seq_code;
      det_start_o <= hv_start;
      det_target_12v_o <= hv_tgt12;
      bias_release_o <= hv_release;
      adapter_level_o <= hv_level;
    end
  end

endmodule // charger_control_regs

// ---- charger_control_defines.vh ----
// register offsets, field positions, reset values and timing counts for the
// charger control register bank; included by every design file of the bank
`ifndef CHARGER_CONTROL_DEFINES_VH
`define CHARGER_CONTROL_DEFINES_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ADDR_CONV_CTL2 8'h17
`define ADDR_PSW_CTL3 8'h18
`define ADDR_PROT_CTL4 8'h19

// ----------------------------------------------------------------------------
// reset values (variant b differs in bit 2 of the protection register)
// ----------------------------------------------------------------------------
`define RST_CONV_CTL2 8'h4F
`define RST_PSW_CTL3 8'h04
`define RST_PROT_CTL4 8'hC0
`define RST_PROT_CTL4_VARB 8'hC4

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BIT_RESTORE 7
`define BIT_THERMAL 6
`define BIT_OVP 0
`define BIT_RSVD_CTL2 1
`define BIT_BOOST_ON 6
`define BIT_BOOST_PFM 5
`define BIT_BUCK_PFM 4
`define BIT_WITH_INPUT 3
`define BIT_PSW_DLY 2
`define BIT_UVLO 5
`define BIT_OTG_MIN 4
`define BIT_REQ9 3
`define BIT_REQ12 2

// ----------------------------------------------------------------------------
// reserved codes and action codes
// ----------------------------------------------------------------------------
`define FREQ_RESERVED 2'h3
`define STRN_RESERVED 2'h2
`define ACT_NORMAL 2'h0
`define ACT_SHUTDOWN 2'h1
`define ACT_SHIP 2'h2
`define ACT_SYS_RESET 2'h3

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_KHZ 40000
`define PSW_SHORT_DLY_MS 20
`define PSW_LONG_DLY_S 10
`define PSW_SHORT_DLY_CYC (`PSW_SHORT_DLY_MS * `CLK_FREQ_KHZ)
`define PSW_LONG_DLY_CYC (`PSW_LONG_DLY_S * 1000 * `CLK_FREQ_KHZ)

`endif

// ---- pass_switch_sequencer.v ----
// delays a requested pass-switch action and fires it once when the delay ends with no adapter present
// assumes the action code and delay select are held steady by the register bank
`timescale 1ns/1ps
`include "charger_control_defines.vh"

module pass_switch_sequencer #(
  parameter SHORT_DLY_CYC = `PSW_SHORT_DLY_CYC,
  parameter LONG_DLY_CYC = `PSW_LONG_DLY_CYC
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire [1:0] action_i,
  input wire long_dly_i,
  input wire adapter_present_i,
  output reg [1:0] fire_code_o,
  output reg fire_o
);

  // ----------------------------------------------------------------------------
  // delay counter
  // ----------------------------------------------------------------------------
  reg [31:0] cnt_r; // cycles left before the action
  reg busy_r; // a delay is running
  reg [1:0] code_r; // action captured at start

  // a change of code restarts the delay; the code returning to normal cancels it
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= 32'h00000000;
      busy_r <= 1'b0;
      code_r <= 2'h0;
      fire_o <= 1'b0;
      fire_code_o <= 2'h0;
    end else begin
      fire_o <= 1'b0;
      if (action_i == `ACT_NORMAL) begin
        busy_r <= 1'b0; // cancelled
        code_r <= `ACT_NORMAL;
      end else if (!busy_r || action_i != code_r) begin
        busy_r <= 1'b1;
        code_r <= action_i;
        // delay chosen by the delay select bit
        cnt_r <= long_dly_i ? LONG_DLY_CYC[31:0] - 32'h00000001 :
                              SHORT_DLY_CYC[31:0] - 32'h00000001;
      end else if (cnt_r != 32'h00000000) begin
        cnt_r <= cnt_r - 32'h00000001;
      end else begin
        busy_r <= 1'b0;
        // with an adapter present the action stays blocked
        if (!adapter_present_i) begin
          fire_o <= 1'b1;
          fire_code_o <= code_r;
        end
      end
    end
  end

endmodule // pass_switch_sequencer

// ---- hv_negotiator.v ----
// sequences high-voltage adapter detection from the two request bits
// assumes a detection front end that answers each start with one done pulse
`timescale 1ns/1ps
`include "charger_control_defines.vh"

module hv_negotiator (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire enable_i,
  input wire nine_volt_request_i,
  input wire twelve_volt_request_i,
  input wire det_done_i,
  input wire det_ok_i,
  output reg det_start_o,
  output reg det_target_12v_o,
  output reg bias_release_o,
  output reg [1:0] adapter_level_o
);

  // ----------------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------------
  localparam ST_DCP = 3'h0; // dedicated charger, no negotiation
  localparam ST_DET9 = 3'h1;
  localparam ST_DET12 = 3'h2;
  localparam ST_GOT9 = 3'h3;
  localparam ST_GOT12 = 3'h4;

  reg [2:0] st_r; // current state
  reg armed_r; // both requests seen cleared since last run

  // from ST_DCP, requests only start a run after both were cleared first
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= ST_DCP;
      armed_r <= 1'b0;
      det_start_o <= 1'b0;
      det_target_12v_o <= 1'b0;
      bias_release_o <= 1'b0;
      adapter_level_o <= 2'h0;
    end else begin
      det_start_o <= 1'b0;
      bias_release_o <= 1'b0;
      if (!enable_i) begin
        st_r <= ST_DCP;
        armed_r <= 1'b0;
        adapter_level_o <= 2'h0;
      end else begin
        case (st_r)
          ST_DCP: begin
            if (!nine_volt_request_i && !twelve_volt_request_i) begin
              armed_r <= 1'b1;
            end else if (armed_r) begin
              armed_r <= 1'b0;
              det_start_o <= 1'b1;
              // twelve volts tried first when both are asked
              det_target_12v_o <= twelve_volt_request_i;
              st_r <= twelve_volt_request_i ? ST_DET12 : ST_DET9;
            end
          end
          ST_DET12: begin
            if (det_done_i && det_ok_i) begin
              st_r <= ST_GOT12; // nine volt step skipped
              adapter_level_o <= 2'h2;
            end else if (det_done_i && nine_volt_request_i) begin
              det_start_o <= 1'b1;
              det_target_12v_o <= 1'b0;
              st_r <= ST_DET9;
            end else if (det_done_i) begin
              bias_release_o <= 1'b1;
              st_r <= ST_DCP;
            end
          end
          ST_DET9: begin
            if (det_done_i && det_ok_i) begin
              st_r <= ST_GOT9;
              adapter_level_o <= 2'h1;
            end else if (det_done_i) begin
              bias_release_o <= 1'b1;
              st_r <= ST_DCP;
            end
          end
          ST_GOT9: begin
            if (!nine_volt_request_i && twelve_volt_request_i) begin
              det_start_o <= 1'b1;
              det_target_12v_o <= 1'b1;
              st_r <= ST_DET12;
            end else if (!nine_volt_request_i) begin
              bias_release_o <= 1'b1;
              adapter_level_o <= 2'h0;
              st_r <= ST_DCP;
            end
          end
          ST_GOT12: begin
            if (!twelve_volt_request_i && nine_volt_request_i) begin
              det_start_o <= 1'b1;
              det_target_12v_o <= 1'b0;
              st_r <= ST_DET9;
            end else if (!twelve_volt_request_i) begin
              bias_release_o <= 1'b1;
              adapter_level_o <= 2'h0;
              st_r <= ST_DCP;
            end
          end
          default: begin
            st_r <= ST_DCP;
          end
        endcase
      end
    end
  end

endmodule // hv_negotiator

// ---- charger_control_regs_properties.sv ----
// checker: port timing of the charger control register bank
// assumes a bind onto the bank's top module ports
`timescale 1ns/1ps
module charger_control_regs_chk (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire wdog_expire_i,
  input wire [7:0] reg_rdata_o,
  input wire timer_reset_o,
  input wire thermal_limit_select_o,
  input wire [1:0] switch_rate_trim_o,
  input wire [1:0] gate_drive_level_o,
  input wire input_overvoltage_level_o,
  input wire boost_output_on_o,
  input wire boost_pulse_skip_off_o,
  input wire buck_pulse_skip_off_o,
  input wire psw_fire_o,
  input wire [1:0] discharge_peak_limit_o,
  input wire cell_undervoltage_level_o,
  input wire boost_min_cell_level_o,
  input wire [2:0] fast_stage_divisor_o,
  input wire det_start_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire w17 = reg_wr_i && reg_addr_i == 8'h17; // write decodes
  wire w18 = reg_wr_i && reg_addr_i == 8'h18;
  wire w19 = reg_wr_i && reg_addr_i == 8'h19;
  // settings show two edges after the write edge
  AST_RESTORE_PULSE: assert property (w17 && reg_wdata_i[7] |=> timer_reset_o)
    else $error("restore gave no timer reset");
  AST_RESTORE_DEF: assert property (w17 && reg_wdata_i[7] ##1 !reg_wr_i |=>
    thermal_limit_select_o && gate_drive_level_o == 2'h3 && !boost_output_on_o
    && fast_stage_divisor_o == 3'h1 && switch_rate_trim_o == 2'h0)
    else $error("restore left a setting");
  AST_THERM_OVP: assert property (w17 && !reg_wdata_i[7] |-> ##2
    {thermal_limit_select_o, input_overvoltage_level_o}
    == {$past(reg_wdata_i[6], 2), $past(reg_wdata_i[0], 2)}) else $error("thermal or ovp");
  AST_TRIM: assert property (w17 && !reg_wdata_i[7] && reg_wdata_i[5:4] != 2'h3 |->
    ##2 switch_rate_trim_o == $past(reg_wdata_i[5:4], 2)) else $error("rate trim");
  AST_DRIVE: assert property (w17 && !reg_wdata_i[7] && reg_wdata_i[3:2] != 2'h2 |->
    ##2 gate_drive_level_o == $past(reg_wdata_i[3:2], 2)) else $error("gate drive");
  AST_MODES: assert property (w18 && !wdog_expire_i ##1 !wdog_expire_i |->
    ##1 {boost_output_on_o, boost_pulse_skip_off_o, buck_pulse_skip_off_o}
    == $past(reg_wdata_i[6:4], 2)) else $error("mode bits");
  AST_WDOG: assert property (wdog_expire_i && !w18 ##1 !w18 |=> !boost_output_on_o)
    else $error("boost kept after watchdog");
  AST_PROT: assert property (w19 |-> ##2
    {discharge_peak_limit_o, cell_undervoltage_level_o, boost_min_cell_level_o}
    == $past(reg_wdata_i[7:4], 2)) else $error("protection fields");
  AST_DIV: assert property (w19 |-> ##2 fast_stage_divisor_o ==
    (($past(reg_wdata_i[1:0], 2) == 2'h3) ? 3'h6 : (3'h1 << $past(reg_wdata_i[1:0], 2))))
    else $error("divisor");
  AST_RO_BITS: assert property (reg_rd_i && reg_addr_i == 8'h18 |=>
    !reg_rdata_o[3] && !reg_rdata_o[7]) else $error("read-only bit set");
  COV_RESTORE: cover property (w17 && reg_wdata_i[7]);
  COV_FIRE: cover property (psw_fire_o);
  COV_DET: cover property (det_start_o);
endmodule // charger_control_regs_chk
bind charger_control_regs charger_control_regs_chk u_chk (.core_clk_i, .sys_rst_i, .reg_wr_i,
  .reg_rd_i, .reg_addr_i, .reg_wdata_i, .wdog_expire_i, .reg_rdata_o, .timer_reset_o,
  .thermal_limit_select_o, .switch_rate_trim_o, .gate_drive_level_o, .input_overvoltage_level_o,
  .boost_output_on_o, .boost_pulse_skip_off_o, .buck_pulse_skip_off_o, .psw_fire_o,
  .discharge_peak_limit_o, .cell_undervoltage_level_o, .boost_min_cell_level_o,
  .fast_stage_divisor_o, .det_start_o);

// ---- hv_detect_model.sv ----
// detection front end model: one done pulse per start
// assumes the bench sets the outcome before each start
`timescale 1ns/1ps
module hv_detect_model (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire start_i,
  input wire ok_sel_i,
  output reg done_o,
  output reg ok_o
);
  reg [2:0] wait_r; // cycles left before answering
  // answer after a few cycles; outcome toggles when unqualified
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_r <= 3'h0;
      done_o <= 1'b0;
      ok_o <= 1'b0;
    end else begin
      done_o <= wait_r == 3'h1;
      ok_o <= (wait_r == 3'h1) ? ok_sel_i : ~ok_o; // no stale level
      if (start_i) wait_r <= 3'h4;
      else if (wait_r != 3'h0) wait_r <= wait_r - 3'h1;
    end
  end
endmodule // hv_detect_model

// ---- charger_control_regs_tb_top.sv ----
// self-checking bench for the charger control register bank
// assumes the byte strobe port and the detection front end model
`timescale 1ns/1ps
module charger_control_regs_tb_top;
  localparam SHORT = 20; // shortened action delays
  localparam LONG = 50;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg wdog = 1'b0;
  reg adp = 1'b0; // adapter present
  reg ok_sel = 1'b0; // next detection outcome
  reg [7:0] addr = 8'h00;
  reg [7:0] wd = 8'h00;
  wire [7:0] rdata;
  wire [2:0] div;
  wire [1:0] trim, drv, fcode, peak, lvl;
  wire rvalid, trst, therm, ovp, boost, bpfm, buck, fire, uvlo, otgmin, start, t12, brel, done, ok;
  wire ext; // external limit enable
  integer err_count = 0;
  integer samples_checked = 0;
  integer starts = 0; // detection starts seen
  integer i;
  integer n;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (start === 1'b1) starts <= starts + 1;
  charger_control_regs #(.VARIANT_B(0), .SHORT_DLY_CYC(SHORT), .LONG_DLY_CYC(LONG)) DUT (
    .core_clk_i(clk), .sys_rst_i(rst), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_addr_i(addr), .reg_wdata_i(wd), .wdog_expire_i(wdog), .adapter_present_i(adp),
    .det_done_i(done), .det_ok_i(ok), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .timer_reset_o(trst), .thermal_limit_select_o(therm), .switch_rate_trim_o(trim),
    .gate_drive_level_o(drv), .input_overvoltage_level_o(ovp), .boost_output_on_o(boost),
    .boost_pulse_skip_off_o(bpfm), .buck_pulse_skip_off_o(buck), .psw_fire_code_o(fcode),
    .psw_fire_o(fire), .discharge_peak_limit_o(peak), .cell_undervoltage_level_o(uvlo),
    .boost_min_cell_level_o(otgmin), .external_limit_pin_on_o(ext), .fast_stage_divisor_o(div),
    .det_start_o(start), .det_target_12v_o(t12), .bias_release_o(brel), .adapter_level_o(lvl)
  );
  hv_detect_model partner (.core_clk_i(clk), .sys_rst_i(rst), .start_i(start),
    .ok_sel_i(ok_sel), .done_o(done), .ok_o(ok));
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one-cycle strobes, called and returning at a falling edge
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk); // gap between strobes
      addr = a;
      wd = d;
      wr_s = 1'b1;
      @(negedge clk);
      wr_s = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge clk); // gap between strobes
      addr = a;
      rd_s = 1'b1;
      @(negedge clk);
      rd_s = 1'b0;
      chk(rvalid, 8'h01);
      chk(rdata, e);
    end
  endtask
  task psw(input [1:0] code, input lng, input present);
    begin
      adp = present;
      wr(8'h18, {5'h00, lng, code});
      n = 0;
      while (fire !== 1'b1 && n < LONG + 20) begin
        @(negedge clk);
        n = n + 1;
      end
      if (present) chk(fire, 8'h00);
      else begin
        chk(n >= (lng ? LONG : SHORT) && n <= (lng ? LONG : SHORT) + 4, 8'h01);
        chk(fcode, code);
      end
      repeat (2) @(negedge clk);
      adp = 1'b0;
      rd(8'h18, {5'h00, lng, present ? code : 2'h0});
    end
  endtask
  task det(input tgt, input res);
    begin
      ok_sel = res;
      n = 0;
      while (start !== 1'b1 && n < 20) begin
        @(negedge clk);
        n = n + 1;
      end
      chk(t12, tgt);
      repeat (10) @(negedge clk);
    end
  endtask
  task summarize;
    begin
      if (err_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // hang guard: the sequence needs well under 1500 cycles
  initial begin
    #(25 * 4000);
    err_count = err_count + 1;
    summarize;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    rd(8'h17, 8'h4F);
    rd(8'h18, 8'h04);
    rd(8'h19, 8'hC0);
    chk({therm, trim, drv, ovp}, 8'h27);
    chk({peak, div, boost, bpfm, buck}, 8'hC8);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h17, {1'b0, i[0], i[1:0], i[1:0], 1'b0, ~i[0]});
      repeat (2) @(negedge clk);
      chk({therm, ovp}, {i[0], ~i[0]});
      chk(trim, (i == 3) ? 2'h2 : i[1:0]);
      chk(drv, (i == 2) ? 2'h1 : i[1:0]);
      rd(8'h17, {1'b0, i[0], i[1:0], i[1:0], 1'b1, ~i[0]});
    end
    wr(8'h18, 8'hFC);
    repeat (2) @(negedge clk);
    chk({boost, bpfm, buck}, 8'h07);
    rd(8'h18, 8'h74);
    wdog = 1'b1;
    @(negedge clk);
    wdog = 1'b0;
    repeat (2) @(negedge clk);
    chk(boost, 8'h00);
    rd(8'h18, 8'h34);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h19, {i[1:0], i[0], i[1], 2'h0, i[1:0]});
      repeat (2) @(negedge clk);
      chk({peak, uvlo, otgmin, ext}, {i[1:0], i[0], i[1], 1'b0});
      chk(div, (i == 3) ? 3'h6 : 3'h1 << i);
    end
    wr(8'h17, 8'h80);
    chk(trst, 8'h01);
    repeat (2) @(negedge clk);
    chk({therm, drv, bpfm, div}, 8'h71);
    rd(8'h17, 8'h4F);
    rd(8'h18, 8'h04);
    rd(8'h19, 8'hC0);
    for (i = 1; i < 4; i = i + 1) psw(i[1:0], i == 2, 1'b0);
    psw(2'h3, 1'b0, 1'b1);
    wr(8'h19, 8'hC0);
    wr(8'h19, 8'hCC);
    det(1'b1, 1'b1);
    chk(lvl, 8'h02);
    wr(8'h19, 8'hC8);
    det(1'b0, 1'b1);
    chk(lvl, 8'h01);
    wr(8'h19, 8'hC4);
    det(1'b1, 1'b1);
    wr(8'h19, 8'hC0);
    wr(8'h19, 8'hC8);
    det(1'b0, 1'b1);
    wr(8'h19, 8'hC0);
    n = 0;
    while (brel !== 1'b1 && n < 20) begin
      @(negedge clk);
      n = n + 1;
    end
    chk(brel, 8'h01);
    chk(starts, 8'h04);
    summarize;
  end
endmodule // charger_control_regs_tb_top
